/* File: src/cevu_params.svh */
// constants of the exception vectoring unit: vectors, offsets, fields
`ifndef CEVU_PARAMS_SVH
`define CEVU_PARAMS_SVH
// ==========================================================
// vector numbers
`define CEVU_VEC_DE       8'h00
`define CEVU_VEC_NMI      8'h02
`define CEVU_VEC_UD       8'h06
`define CEVU_VEC_DF       8'h08
`define CEVU_VEC_GP       8'h0d
`define CEVU_VEC_PF       8'h0e
`define CEVU_VEC_AC       8'h11
`define CEVU_VEC_MC       8'h12
`define CEVU_VEC_XF       8'h13
// ==========================================================
// decode limits and descriptor geometry
`define CEVU_MAX_ILEN     5'h0f
`define CEVU_DESC_SHIFT   3
// ==========================================================
// register offsets
`define CEVU_A_XCR        8'h00
`define CEVU_A_VTBASE     8'h04
`define CEVU_A_VTLIM      8'h08
`define CEVU_A_VFPCS      8'h0c
`define CEVU_A_STAT       8'h10
// ==========================================================
// fields and reset values
`define CEVU_XCR_VME      0
`define CEVU_XCR_MCE      6
`define CEVU_XCR_RSVD     32'hfffff800
`define CEVU_XCR_RST      32'h00000000
`define CEVU_VFP_RST      32'h00001f80
`define CEVU_VFP_NFLAG    6
`define CEVU_VFP_MASK_LSB 7
`define CEVU_VTLIM_RST    16'h03ff
// ==========================================================
// event sources, lower index wins
`define CEVU_S_TRAP       0
`define CEVU_S_NMI        1
`define CEVU_S_INTR       2
`define CEVU_S_FETCH_PF   3
`define CEVU_S_TESTREG    4
`define CEVU_S_LOCK       5
`define CEVU_S_LEN        6
`define CEVU_S_DIV        7
`define CEVU_S_CREG       8
`define CEVU_S_DATA_PF    9
`define CEVU_S_ALIGN      10
`define CEVU_S_VFP        11
`define CEVU_S_MC         12
`define CEVU_NSRC         13
`endif

/* File: src/cevu_pkg.sv */
// types shared by the exception vectoring unit
package cevu_pkg;
   typedef enum logic [2:0] {
      CEVU_ST_IDLE  = 3'b000,
      CEVU_ST_CHECK = 3'b001,
      CEVU_ST_FETCH = 3'b010,
      CEVU_ST_ENTER = 3'b011,
      CEVU_ST_SHUT  = 3'b100
   } cevu_state_e;
   typedef logic [7:0] cevu_vec_t;
   typedef logic [3:0] cevu_src_t;
endpackage

/* File: src/cevu_pick.sv */
// fixed-order picker: lowest pending source index wins
`timescale 1ns/100ps
`default_nettype none
`include "cevu_params.svh"
module cevu_pick (
   input  wire logic [`CEVU_NSRC-1:0] elig,
   output logic                      any,
   output cevu_pkg::cevu_src_t       idx
);
   import cevu_pkg::*;
   // scan from the top end down so the lowest index is kept last
   always_comb begin
      any = |elig;
      idx = 4'h0;
      for (int i = `CEVU_NSRC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            idx = cevu_src_t'(i);
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/cevu_tss.sv */
// task-state save and restore formatting
`timescale 1ns/100ps
`default_nettype none
module cevu_tss (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic        ts_req,
   input  wire logic        ts_old16,
   input  wire logic        ts_new16,
   input  wire logic [15:0] sel_in,
   input  wire logic [31:0] flags_in,
   input  wire logic        new_vm_flag,
   output logic             ts_done,
   output logic [31:0]      sel_word,
   output logic [31:0]      flags_word,
   output logic             flags_hi_we,
   output logic             page_dir_base_load,
   output logic             v86_restore
);
   // one registered answer per task-switch request
   always_ff @(posedge mclk) begin
      if (srst) begin
         ts_done            <= 1'b0;
         sel_word           <= 32'h00000000;
         flags_word         <= 32'h00000000;
         flags_hi_we        <= 1'b0;
         page_dir_base_load <= 1'b0;
         v86_restore        <= 1'b0;
      end else begin
         ts_done <= ts_req;
         if (ts_req) begin
            sel_word    <= {16'h0000, sel_in};
            // a narrow segment gets only the low half of the flags
            flags_word  <= ts_old16 ? {16'h0000, flags_in[15:0]}
                                    : flags_in;
            flags_hi_we <= ~ts_old16;
            page_dir_base_load <= ~ts_new16;
            // vm flag lives in the upper half, never saved there
            v86_restore <= new_vm_flag & ~ts_new16;
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/cevu_core.sv */
// exception recognition, prioritising and vector-table delivery
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "cevu_params.svh"
module cevu_core (
   input  wire logic                 mclk,
   input  wire logic                 srst,
   // register port
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   // pipeline events
   input  wire logic                 instr_boundary,
   input  wire logic [31:0]          cur_ip,
   input  wire logic [31:0]          next_ip,
   input  wire logic                 trap_evt,
   input  wire cevu_pkg::cevu_vec_t  trap_vec,
   input  wire logic                 fetch_rsvd_entry,
   input  wire logic                 testreg_mov,
   input  wire logic                 lock_misuse,
   input  wire logic                 decode_valid,
   input  wire logic [4:0]           instr_len,
   input  wire logic                 div_op,
   input  wire logic                 div_by_zero,
   input  wire logic                 div_quot_ovf,
   input  wire logic                 div_quot_min,
   input  wire logic                 data_rsvd_entry,
   input  wire logic                 misalign_ref,
   input  wire logic                 align_check_on,
   input  wire logic [5:0]           vfp_exc,
   input  wire logic                 hw_error,
   input  wire logic                 irq_return_op,
   // external interrupt sources
   input  wire logic                 nmi_evt,
   input  wire logic                 intr_req,
   input  wire logic                 intr_enable,
   input  wire cevu_pkg::cevu_vec_t  intr_vec,
   output logic                      intr_ack,
   // virtual-8086 redirection
   input  wire logic                 v86_mode,
   input  wire logic                 redir_bit,
   output logic                      redir_to_v86,
   // vector-table read and handler entry
   output logic                      desc_rd_req,
   output logic [31:0]               desc_rd_addr,
   input  wire logic                 desc_rd_ack,
   output logic                      handler_go,
   output cevu_pkg::cevu_vec_t       handler_vec,
   output logic [31:0]               handler_ip,
   output logic                      shutdown,
   output logic                      nmi_blocked,
   // task switch
   input  wire logic                 ts_req,
   input  wire logic                 ts_old16,
   input  wire logic                 ts_new16,
   input  wire logic [15:0]          sel_in,
   input  wire logic [31:0]          flags_in,
   input  wire logic                 new_vm_flag,
   output logic                      ts_done,
   output logic [31:0]               sel_word,
   output logic [31:0]               flags_word,
   output logic                      flags_hi_we,
   output logic                      page_dir_base_load,
   output logic                      v86_restore
);
   import cevu_pkg::*;

   // ==========================================================
   // registers and state
   logic [31:0]           ext_ctrl;
   logic [31:0]           vt_base;
   logic [15:0]           vt_limit;
   logic [31:0]           vfp_cs;
   logic                  trap_pend;
   cevu_vec_t             trap_vec_q;
   logic                  nmi_pend;
   logic [`CEVU_NSRC-1:3] flt_pend;
   logic [`CEVU_NSRC-1:3] flt_set;
   logic [`CEVU_NSRC-1:0] elig;
   logic                  pick_any;
   cevu_src_t             pick_idx;
   cevu_vec_t             pick_vec;
   logic                  take;
   cevu_state_e           state;
   cevu_vec_t             cur_vec;
   cevu_src_t             cur_src;
   logic                  xcr_wr;
   logic                  xcr_bad;
   logic [5:0]            vfp_unmasked;

   // last byte of an 8-byte entry must lie inside the limit
   function automatic logic entry_over(input cevu_vec_t v,
                                       input logic [15:0] lim);
      entry_over = ({5'h00, v, 3'b111} > lim);
   endfunction

   assign xcr_wr  = reg_wr && (reg_addr == `CEVU_A_XCR);
   assign xcr_bad = |(reg_wdata & `CEVU_XCR_RSVD);
   assign vfp_unmasked = vfp_exc & ~vfp_cs[`CEVU_VFP_MASK_LSB +: 6];

   // ==========================================================
   // fault detection, one set bit per source
   always_comb begin
      flt_set = '0;
      flt_set[`CEVU_S_FETCH_PF] = fetch_rsvd_entry;
      flt_set[`CEVU_S_TESTREG]  = testreg_mov;
      flt_set[`CEVU_S_LOCK]     = lock_misuse;
      flt_set[`CEVU_S_LEN]      = decode_valid &&
                                  (instr_len > `CEVU_MAX_ILEN);
      // the most negative quotient is representable, so no fault
      flt_set[`CEVU_S_DIV]      = div_op && (div_by_zero ||
                                  (div_quot_ovf && !div_quot_min));
      flt_set[`CEVU_S_CREG]     = xcr_wr && xcr_bad;
      flt_set[`CEVU_S_DATA_PF]  = data_rsvd_entry;
      flt_set[`CEVU_S_ALIGN]    = misalign_ref && align_check_on;
      flt_set[`CEVU_S_VFP]      = |vfp_unmasked;
      flt_set[`CEVU_S_MC]       = hw_error &&
                                  ext_ctrl[`CEVU_XCR_MCE];
   end

   // ==========================================================
   // pending faults; a new event wins over the clear of a take
   always_ff @(posedge mclk) begin
      if (srst) begin
         flt_pend <= '0;
      end else begin
         for (int i = 3; i < `CEVU_NSRC; i++) begin
            if (flt_set[i]) begin
               flt_pend[i] <= 1'b1;
            end else if (take && (pick_idx == cevu_src_t'(i))) begin
               flt_pend[i] <= 1'b0;
            end
         end
      end
   end

   // previous-instruction trap, vector held with it
   always_ff @(posedge mclk) begin
      if (srst) begin
         trap_pend  <= 1'b0;
         trap_vec_q <= 8'h00;
      end else if (trap_evt) begin
         trap_pend  <= 1'b1;
         trap_vec_q <= trap_vec;
      end else if (take && (pick_idx == `CEVU_S_TRAP)) begin
         trap_pend  <= 1'b0;
      end
   end

   // non-maskable interrupt: latched edge plus block until return
   always_ff @(posedge mclk) begin
      if (srst) begin
         nmi_pend    <= 1'b0;
         nmi_blocked <= 1'b0;
      end else begin
         if (nmi_evt) begin
            nmi_pend <= 1'b1;
         end else if (take && (pick_idx == `CEVU_S_NMI)) begin
            nmi_pend <= 1'b0;
         end
         if (take && (pick_idx == `CEVU_S_NMI)) begin
            nmi_blocked <= 1'b1;
         end else if (irq_return_op) begin
            nmi_blocked <= 1'b0;
         end
      end
   end

   // ==========================================================
   // prioritise: index order follows the five categories
   assign elig = {flt_pend,
                  intr_req && intr_enable,
                  nmi_pend && !nmi_blocked,
                  trap_pend};

   cevu_pick u_pick (
      .elig (elig),
      .any  (pick_any),
      .idx  (pick_idx)
   );

   always_comb begin
      unique case (pick_idx)
         `CEVU_S_TRAP:    pick_vec = trap_vec_q;
         `CEVU_S_NMI:     pick_vec = `CEVU_VEC_NMI;
         `CEVU_S_INTR:    pick_vec = intr_vec;
         `CEVU_S_TESTREG,
         `CEVU_S_LOCK:    pick_vec = `CEVU_VEC_UD;
         `CEVU_S_LEN,
         `CEVU_S_CREG:    pick_vec = `CEVU_VEC_GP;
         `CEVU_S_FETCH_PF,
         `CEVU_S_DATA_PF: pick_vec = `CEVU_VEC_PF;
         `CEVU_S_DIV:     pick_vec = `CEVU_VEC_DE;
         `CEVU_S_ALIGN:   pick_vec = `CEVU_VEC_AC;
         `CEVU_S_VFP:     pick_vec = `CEVU_VEC_XF;
         `CEVU_S_MC:      pick_vec = `CEVU_VEC_MC;
         default:         pick_vec = `CEVU_VEC_DF;
      endcase
   end

   // at most one event leaves per boundary, only while idle
   assign take     = instr_boundary && pick_any &&
                     (state == CEVU_ST_IDLE);
   assign intr_ack = take && (pick_idx == `CEVU_S_INTR);

   // redirection only applies in v86 with the extensions on
   assign redir_to_v86 = ext_ctrl[`CEVU_XCR_VME] && v86_mode &&
                         redir_bit;

   // ==========================================================
   // delivery sequencer; shutdown is left only by reset
   always_ff @(posedge mclk) begin
      if (srst) begin
         state   <= CEVU_ST_IDLE;
         cur_vec <= 8'h00;
         cur_src <= 4'h0;
      end else begin
         unique case (state)
            CEVU_ST_IDLE: begin
               if (take) begin
                  cur_vec <= pick_vec;
                  cur_src <= pick_idx;
                  state   <= CEVU_ST_CHECK;
               end
            end
            CEVU_ST_CHECK: begin
               if (!entry_over(cur_vec, vt_limit)) begin
                  state <= CEVU_ST_FETCH;
               end else if (cur_vec == `CEVU_VEC_DF) begin
                  state <= CEVU_ST_SHUT;
               end else begin
                  cur_vec <= `CEVU_VEC_DF;
               end
            end
            CEVU_ST_FETCH: begin
               if (desc_rd_ack) begin
                  state <= CEVU_ST_ENTER;
               end
            end
            CEVU_ST_ENTER: state <= CEVU_ST_IDLE;
            CEVU_ST_SHUT:  state <= CEVU_ST_SHUT;
            default:       state <= CEVU_ST_IDLE;
         endcase
      end
   end

   assign desc_rd_req = (state == CEVU_ST_FETCH);
   assign handler_go  = (state == CEVU_ST_ENTER);
   assign shutdown    = (state == CEVU_ST_SHUT);

   // table address and handler data, registered for the pipeline
   always_ff @(posedge mclk) begin
      if (srst) begin
         desc_rd_addr <= 32'h00000000;
         handler_vec  <= 8'h00;
      end else if (state == CEVU_ST_CHECK) begin
         desc_rd_addr <= vt_base +
                         {21'h000000, cur_vec, 3'b000};
         handler_vec  <= cur_vec;
      end
   end

   // faults restart the instruction; traps and interrupts resume after
   always_ff @(posedge mclk) begin
      if (srst) begin
         handler_ip <= 32'h00000000;
      end else if (take) begin
         handler_ip <= (pick_idx >= `CEVU_S_FETCH_PF) ? cur_ip
                                                     : next_ip;
      end
   end

   // ==========================================================
   // software registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         ext_ctrl <= `CEVU_XCR_RST;
         vt_base  <= 32'h00000000;
         vt_limit <= `CEVU_VTLIM_RST;
      end else if (reg_wr) begin
         // a write with a reserved bit is refused whole
         if (xcr_wr && !xcr_bad) begin
            ext_ctrl <= reg_wdata;
         end
         if (reg_addr == `CEVU_A_VTBASE) begin
            vt_base <= reg_wdata;
         end
         if (reg_addr == `CEVU_A_VTLIM) begin
            vt_limit <= reg_wdata[15:0];
         end
      end
   end

   // vector float flags are sticky; a new flag wins over the write
   always_ff @(posedge mclk) begin
      if (srst) begin
         vfp_cs <= `CEVU_VFP_RST;
      end else if (reg_wr && (reg_addr == `CEVU_A_VFPCS)) begin
         vfp_cs <= reg_wdata | {26'h0000000, vfp_exc};
      end else begin
         vfp_cs <= vfp_cs | {26'h0000000, vfp_exc};
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (srst || !reg_rd) begin
         reg_rdata <= 32'h00000000;
      end else begin
         unique case (reg_addr)
            `CEVU_A_XCR:    reg_rdata <= ext_ctrl;
            `CEVU_A_VTBASE: reg_rdata <= vt_base;
            `CEVU_A_VTLIM:  reg_rdata <= {16'h0000, vt_limit};
            `CEVU_A_VFPCS:  reg_rdata <= vfp_cs;
            `CEVU_A_STAT:   reg_rdata <= {19'h00000, shutdown,
                                          nmi_blocked, state, cur_vec};
            default:        reg_rdata <= 32'h00000000;
         endcase
      end
   end

   // ==========================================================
   // task-state formatting
   cevu_tss u_tss (
      .mclk               (mclk),
      .srst               (srst),
      .ts_req             (ts_req),
      .ts_old16           (ts_old16),
      .ts_new16           (ts_new16),
      .sel_in             (sel_in),
      .flags_in           (flags_in),
      .new_vm_flag        (new_vm_flag),
      .ts_done            (ts_done),
      .sel_word           (sel_word),
      .flags_word         (flags_word),
      .flags_hi_we        (flags_hi_we),
      .page_dir_base_load (page_dir_base_load),
      .v86_restore        (v86_restore)
   );

   // ==========================================================
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   a_nmi_block_set: assert property (
      take && (pick_idx == `CEVU_S_NMI) |=> nmi_blocked)
      else $error("nmi not blocked after being taken");
   a_nmi_no_retake: assert property (
      nmi_blocked |-> !(take && (pick_idx == `CEVU_S_NMI)))
      else $error("nmi taken while blocked");
   a_limit_df: assert property (
      (state == CEVU_ST_CHECK) && entry_over(cur_vec, vt_limit) &&
      (cur_vec != `CEVU_VEC_DF)
      |=> (state == CEVU_ST_CHECK) && (cur_vec == `CEVU_VEC_DF))
      else $error("over-limit vector did not become double fault");
   a_df_shutdown: assert property (
      (state == CEVU_ST_CHECK) && (cur_vec == `CEVU_VEC_DF) &&
      entry_over(cur_vec, vt_limit) |=> shutdown [*3])
      else $error("double fault over limit did not shut down");
   a_mc_gated: assert property (
      !ext_ctrl[`CEVU_XCR_MCE] && !flt_pend[`CEVU_S_MC]
      |=> !flt_pend[`CEVU_S_MC])
      else $error("hardware abort raised while disabled");
   a_len_gp: assert property (
      decode_valid && (instr_len > `CEVU_MAX_ILEN)
      |=> flt_pend[`CEVU_S_LEN])
      else $error("over-long instruction not flagged");
   a_div_min_ok: assert property (
      !flt_pend[`CEVU_S_DIV] && div_op && !div_by_zero && div_quot_min
      |=> !flt_pend[`CEVU_S_DIV])
      else $error("most negative quotient raised divide fault");
   a_fault_ptr: assert property (
      take && (pick_idx == `CEVU_S_DIV)
      |=> handler_ip == $past(cur_ip))
      else $error("divide fault pointer not at faulting instruction");
   a_vec_latched: assert property (
      take |=> (state == CEVU_ST_CHECK) && (cur_vec == $past(pick_vec)) &&
      (cur_src == $past(pick_idx)) ##1 !take)
      else $error("vector not latched before table read");
   a_creg_refuse: assert property (
      xcr_wr && xcr_bad
      |=> flt_pend[`CEVU_S_CREG] && (ext_ctrl == $past(ext_ctrl)))
      else $error("reserved control write not refused");
   a_vfp_record: assert property (
      |vfp_unmasked |=> flt_pend[`CEVU_S_VFP] &&
      ((vfp_cs[5:0] & $past(vfp_exc)) == $past(vfp_exc)))
      else $error("vector float flags not recorded with fault");
endmodule
`default_nettype wire

/* File: testbench/cevu_tbl_model.sv */
// stand-in for the vector-table reader
`timescale 1ns/100ps
`default_nettype none
module cevu_tbl_model (
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       req,
   input  wire logic [1:0] dly,
   output logic            ack
);
   logic [1:0] cnt;
   // late answers by dly cycles; one ack per request, never held
   always_ff @(posedge mclk) begin
      cnt <= (srst || !req || ack) ? 2'h0 : cnt + 2'h1;
      ack <= !srst && req && !ack && cnt >= dly;
   end
endmodule
`default_nettype wire

/* File: testbench/cevu_core_tb.sv */
// self-checking bench of the exception vectoring unit
`timescale 1ns/100ps
`default_nettype none
`include "cevu_params.svh"
`define C(a,b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module cevu_core_tb;
   import cevu_pkg::*;
   logic        mclk = 0, srst = 1, wr = 0, rd = 0, ack, go, nb, sd, rv, req;
   logic        td, fhw, pdl, v8r, ia, bd = 1;
   logic [7:0]  ad = 0, hv;
   logic [12:0] e = 0;
   logic [11:0] q = 0;
   logic [31:0] wd = 0, rdat, hip, sw, fw, da, ip = 0, r = 32'hdb03282f;
   int          err_total = 0, total_checks = 0, n_ack = 0;
   // xorshift; the fixed seed keeps runs repeatable
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13; s ^= s >> 17; return s ^ (s << 5);
   endfunction
   initial forever #12.5 mclk = ~mclk;
   cevu_tbl_model tbl_u (.mclk(mclk), .srst(srst), .req(req), .dly(r[1:0]),
      .ack(ack));
   cevu_core dut_u (.mclk(mclk), .srst(srst), .reg_addr(ad), .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .instr_boundary(bd),
      .cur_ip(ip), .next_ip(ip + 32'h4), .trap_evt(e[10]), .trap_vec(8'h20),
      .fetch_rsvd_entry(e[2]), .testreg_mov(e[0]), .lock_misuse(e[1]),
      .decode_valid(e[9]), .instr_len({q[9], 4'hf}), .div_op(e[5]),
      .div_by_zero(q[1]), .div_quot_ovf(q[2]), .div_quot_min(q[3]),
      .data_rsvd_entry(e[3]), .misalign_ref(e[4]), .align_check_on(q[0]),
      .vfp_exc({5'h00, e[12]}), .hw_error(e[6]), .irq_return_op(e[7]),
      .nmi_evt(e[8]), .intr_req(q[10]), .intr_enable(q[11]),
      .intr_vec(8'h40), .intr_ack(ia), .v86_mode(q[7]), .redir_bit(q[8]),
      .redir_to_v86(rv), .desc_rd_req(req), .desc_rd_addr(da),
      .desc_rd_ack(ack), .handler_go(go), .handler_vec(hv),
      .handler_ip(hip), .shutdown(sd), .nmi_blocked(nb), .ts_req(e[11]),
      .ts_old16(q[4]), .ts_new16(q[5]), .sel_in(r[15:0]), .flags_in(r),
      .new_vm_flag(q[6]), .ts_done(td), .sel_word(sw), .flags_word(fw),
      .flags_hi_we(fhw), .page_dir_base_load(pdl), .v86_restore(v8r));
   // count acknowledges; only one interrupt is ever offered
   always @(negedge mclk) if (ia === 1'b1) n_ack++;
   // register port: one-cycle strobes, read data seen the cycle after
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk); ad <= a; wd <= d; wr <= 1'b1;
      @(posedge mclk); wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      @(posedge mclk); ad <= a; rd <= 1'b1;
      @(posedge mclk); rd <= 1'b0;
      @(negedge mclk); `C(rdat, x)
   endtask
   // one-cycle event pulse with qualifiers and a fresh random ip
   task automatic f(input logic [12:0] m, input logic [11:0] k);
      @(posedge mclk); ip <= r; r <= xs(r); q <= k; e <= m;
      @(posedge mclk); e <= '0;
   endtask
   // bounded wait for handler entry; late table answers stretch it
   task automatic wt(input cevu_vec_t v);
      @(negedge mclk);
      for (int i = 0; i < 40 && go !== 1'b1; i++) @(negedge mclk);
      `C(go, 1'b1) `C(hv, v)
      `C(da, 32'h1000 + {21'h0, v, 3'b000})
      $display("event %h done", v);
   endtask
   task automatic nt;
      repeat (8) @(negedge mclk) `C(go, 1'b0)
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // a few hundred cycles suffice; far more means a hang
   initial begin
      #100us;
      err_total++;
      tally_and_finish;
   end
   initial begin
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      rc(`CEVU_A_XCR, `CEVU_XCR_RST);
      rc(`CEVU_A_VFPCS, `CEVU_VFP_RST);
      rc(8'h44, 32'h0);
      rc(`CEVU_A_VTLIM, 32'h3ff);
      w(`CEVU_A_VTBASE, 32'h1000); rc(`CEVU_A_VTBASE, 32'h1000);
      f(13'h0001, 12'h0); wt(`CEVU_VEC_UD);
      f(13'h0002, 12'h0); wt(`CEVU_VEC_UD);
      f(13'h0010, 12'h1); wt(`CEVU_VEC_AC);
      f(13'h0020, 12'h2); wt(`CEVU_VEC_DE);
      `C(hip, ip)
      f(13'h0020, 12'hc); nt;
      f(13'h0200, 12'h0); nt;
      f(13'h0200, 12'h200); wt(`CEVU_VEC_GP);
      f(13'h0040, 12'h0); nt;
      w(`CEVU_A_XCR, 32'h41);
      f(13'h0040, 12'h180); wt(`CEVU_VEC_MC);
      `C(rv, 1'b1)
      w(`CEVU_A_XCR, 32'h841); wt(`CEVU_VEC_GP);
      rc(`CEVU_A_XCR, 32'h41);
      // interrupt held only through its take, faults stay pending
      f(13'h000d, 12'hc00); q <= '0;
      wt(8'h40); wt(`CEVU_VEC_PF); wt(`CEVU_VEC_UD);
      wt(`CEVU_VEC_PF);
      f(13'h0401, 12'h0); wt(8'h20); wt(`CEVU_VEC_UD);
      f(13'h0100, 12'h0); wt(`CEVU_VEC_NMI); `C(nb, 1'b1)
      f(13'h0100, 12'h0); nt;
      f(13'h0080, 12'h0); wt(`CEVU_VEC_NMI);
      // no boundary, no take: the event waits until one comes
      @(posedge mclk); bd <= 1'b0; f(13'h0002, 12'h0); nt;
      @(posedge mclk); bd <= 1'b1; wt(`CEVU_VEC_UD);
      w(`CEVU_A_VFPCS, 32'h0);
      f(13'h1000, 12'h0); wt(`CEVU_VEC_XF);
      rc(`CEVU_A_VFPCS, 32'h1);
      f(13'h0800, 12'h070); @(negedge mclk);
      `C({td, sw}, {17'h10000, r[15:0]})
      `C({fw, fhw}, {16'h0, r[15:0], 1'b0})
      `C({pdl, v8r}, 2'b00)
      f(13'h0800, 12'h040); @(negedge mclk);
      `C({fw, fhw, pdl, v8r}, {r, 3'b111})
      w(`CEVU_A_VTLIM, 32'h47); f(13'h0200, 12'h200);
      wt(`CEVU_VEC_DF);
      w(`CEVU_A_VTLIM, 32'h40); f(13'h0200, 12'h200);
      nt; `C(sd, 1'b1)
      rc(`CEVU_A_STAT, 32'h1c08);
      `C(n_ack, 1)
      tally_and_finish;
   end
endmodule
`default_nettype wire
